//--- src/plsc_pkg.sv
package plsc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_LINK_CAP = 8'h00;
    localparam logic [7:0] OFF_LINK_STAT = 8'h04;
    localparam logic [7:0] OFF_SLOT_CAP = 8'h08;
    localparam logic [7:0] OFF_SLOT_CTRL = 8'h0C;
    localparam logic [7:0] OFF_PCIE_CAP = 8'h10;
    localparam logic [7:0] OFF_INT_STAT = 8'h14;
    localparam logic [7:0] OFF_INT_EN = 8'h18;
    localparam logic [7:0] OFF_INT_CLR = 8'h1C;

    // field positions
    localparam int LCAP_PORT_LSB = 24;
    localparam int LCAP_DLLA_BIT = 20;
    localparam int LCAP_SDN_BIT = 19;
    localparam int LSTAT_SLOTCLK_BIT = 12;
    localparam int LSTAT_DLLA_BIT = 13;
    localparam int SCAP_SCALE_LSB = 15;
    localparam int SCAP_LIMIT_LSB = 7;
    localparam int PCAP_SLOT_BIT = 8;
    localparam int INT_SDN_BIT = 0;
    localparam int INT_SPL_BIT = 1;

    // fixed capability values and reset values
    localparam logic [7:0] PORT_NUMBER = 8'h01;
    localparam logic [1:0] SCALE_RST = 2'h0;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam logic [1:0] INT_RST = 2'h0;
    localparam int NUM_EVT = 2;

    // message sender timing
    localparam int MSG_HOLD_CYC = 1;

    typedef enum logic [1:0] {
        PLSC_SCALE_1X = 2'h0,
        PLSC_SCALE_0P1X = 2'h1,
        PLSC_SCALE_0P01X = 2'h2,
        PLSC_SCALE_0P001X = 2'h3
    } plsc_scale_e;

    typedef enum logic [1:0] {
        PLSC_MSG_IDLE = 2'h0,
        PLSC_MSG_REQ = 2'h1,
        PLSC_MSG_WAIT = 2'h3
    } plsc_msg_e;

    typedef struct packed {
        plsc_scale_e scale;
        logic [7:0] limit;
    } plsc_power_s;

endpackage

//--- src/plsc_msg_tx.sv
`timescale 1ns/1ns
module plsc_msg_tx
    import plsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic kick,
    input wire plsc_power_s power,
    output plsc_power_s msg_power,
    output logic msg_valid,
    input wire logic msg_ready
);

    plsc_msg_e st_r, st_nxt;
    plsc_power_s pw_r, pw_nxt;
    logic pend_r, pend_nxt;
    logic v_r, v_nxt;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        pw_nxt = pw_r;
        pend_nxt = pend_r | kick;
        v_nxt = v_r;
        case (st_r)
            PLSC_MSG_IDLE: begin
                if (pend_r | kick) begin
                    st_nxt = PLSC_MSG_REQ;
                    pw_nxt = power;
                    pend_nxt = 1'b0;
                    v_nxt = 1'b1;
                end
            end
            PLSC_MSG_REQ: begin
                if (msg_ready) begin
                    st_nxt = PLSC_MSG_WAIT;
                    v_nxt = 1'b0;
                end
            end
            PLSC_MSG_WAIT: st_nxt = PLSC_MSG_IDLE;
            default: st_nxt = PLSC_MSG_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= PLSC_MSG_IDLE;
            pw_r <= '{scale: PLSC_SCALE_1X, limit: LIMIT_RST};
            pend_r <= 1'b0;
            v_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            pw_r <= pw_nxt;
            pend_r <= pend_nxt;
            v_r <= v_nxt;
        end
    end

    assign msg_power = pw_r;
    assign msg_valid = v_r;

    ////////////////////////////////////////////////////////////////////
    a_msg_follows_kick: assert property (@(posedge aclk) // see [R5]
        disable iff (!aresetn)
        (ce && kick && st_r == PLSC_MSG_IDLE) |=> msg_valid)
        else $error("message not raised after slot power write");

    sequence s_offer;
        msg_valid && !msg_ready;
    endsequence
    a_msg_holds: assert property (@(posedge aclk) // see [R5]
        disable iff (!aresetn)
        (s_offer and ce) |=> msg_valid && $stable(msg_power))
        else $error("message dropped or changed before taken");

endmodule

//--- src/plsc_top.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// [R1] root port number in link capabilities reads back fixed 0x01.
// [R2] common reference clock option sets link status bit 12.
// [R3] slot power scale codes: 0=1.0x, 1=0.1x, 2=0.01x, 3=0.001x.
// [R4] slot power scale holds zero after reset.
// [R5] each write to slot power scale sends a set slot power message; writes made while a message is still pending share one message.
// [R6] integrator enables link active reporting for hot-plug endpoints.
// [R7] surprise down reporting detects and reports the error, readable.
// [R8] slot capability exists only in root port mode with a slot.
// [R9] build-time capability values are read-only constants.
module plsc_top
    import plsc_pkg::*;
#(
    parameter bit ROOT_PORT = 1'b1,
    parameter bit DLL_ACTIVE_REP = 1'b1,
    parameter bit SURPRISE_DOWN_REP = 1'b1,
    parameter bit COMMON_REFCLK = 1'b1,
    parameter bit SLOT_IMPL = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_up,
    output plsc_power_s msg_power,
    output logic msg_valid,
    input wire logic msg_ready,
    output logic irq
);

    localparam bit SLOT_EN = ROOT_PORT && SLOT_IMPL; // see [R8]
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////
    // write channel state
    logic aw_hold_r, aw_hold_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    // read channel state
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    // block state
    plsc_power_s pw_r, pw_nxt;
    logic [NUM_EVT-1:0] ist_r, ist_nxt;
    logic [NUM_EVT-1:0] ien_r, ien_nxt;
    logic [NUM_EVT-1:0] evt;
    logic [NUM_EVT-1:0] clr;
    logic link_up_d_r, link_up_d_nxt;
    logic irq_r, irq_nxt;
    logic kick;
    logic do_wr;
    logic [31:0] rd_val;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////
    // event sources
    always_comb begin
        evt = '0;
        evt[INT_SDN_BIT] = SURPRISE_DOWN_REP && ROOT_PORT
            && link_up_d_r && !link_up; // see [R7]
        evt[INT_SPL_BIT] = kick;
        link_up_d_nxt = link_up;
    end

    ////////////////////////////////////////////////////////////////////
    // read mux: link and PCIe capability fields are parameters, never writable; slot capability reads back pw_r
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFF_LINK_CAP: begin
                if (ROOT_PORT) begin
                    rd_val[LCAP_PORT_LSB +: 8] = PORT_NUMBER; // see [R1] [R9]
                end
                rd_val[LCAP_DLLA_BIT] = ROOT_PORT && DLL_ACTIVE_REP;
                rd_val[LCAP_SDN_BIT] = ROOT_PORT && SURPRISE_DOWN_REP;
            end
            OFF_LINK_STAT: begin
                rd_val[LSTAT_SLOTCLK_BIT] = COMMON_REFCLK; // see [R2] [R9]
                rd_val[LSTAT_DLLA_BIT] = DLL_ACTIVE_REP && link_up;
            end
            OFF_SLOT_CAP: begin
                if (SLOT_EN) begin
                    rd_val[SCAP_SCALE_LSB +: 2] = pw_r.scale; // see [R3]
                    rd_val[SCAP_LIMIT_LSB +: 8] = pw_r.limit;
                end else begin
                    rd_hit = 1'b0; // see [R8]
                end
            end
            OFF_SLOT_CTRL: rd_hit = 1'b1;
            OFF_PCIE_CAP: rd_val[PCAP_SLOT_BIT] = SLOT_EN; // see [R8]
            OFF_INT_STAT: rd_val[NUM_EVT-1:0] = ist_r;
            OFF_INT_EN: rd_val[NUM_EVT-1:0] = ien_r;
            OFF_INT_CLR: rd_hit = 1'b1;
            default: rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        arready_nxt = 1'b0;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        pw_nxt = pw_r;
        ien_nxt = ien_r;
        clr = '0;
        kick = 1'b0;
        do_wr = aw_hold_r && w_hold_r && !bvalid_r;
        if (s_axi_awvalid && awready_r) begin
            aw_hold_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_hold_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OK;
            case (aw_addr_r)
                OFF_SLOT_CTRL: begin
                    if (SLOT_EN && w_strb_r[0]) begin
                        pw_nxt.limit = w_data_r[7:0];
                    end
                    if (SLOT_EN && w_strb_r[1]) begin
                        pw_nxt.scale = plsc_scale_e'(w_data_r[9:8]);
                        kick = 1'b1; // see [R5]
                    end
                    if (!SLOT_EN) begin
                        bresp_nxt = RESP_ERR;
                    end
                end
                OFF_INT_EN: begin
                    if (w_strb_r[0]) begin
                        ien_nxt = w_data_r[NUM_EVT-1:0];
                    end
                end
                OFF_INT_CLR: begin
                    if (w_strb_r[0]) begin
                        clr = w_data_r[NUM_EVT-1:0];
                    end
                end
                OFF_LINK_CAP, OFF_LINK_STAT, OFF_SLOT_CAP, OFF_PCIE_CAP,
                OFF_INT_STAT: bresp_nxt = RESP_OK; // see [R9]
                default: bresp_nxt = RESP_ERR;
            endcase
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt = !w_hold_nxt && !bvalid_nxt;
        if (s_axi_arvalid && !arready_r && !rvalid_r) begin
            arready_nxt = 1'b1;
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_val;
            rresp_nxt = rd_hit ? RESP_OK : RESP_ERR;
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky status, set wins over clear
    generate
        for (genvar i = 0; i < NUM_EVT; i++) begin : g_ist
            always_comb begin
                ist_nxt[i] = evt[i] | (ist_r[i] & ~clr[i]);
            end
        end
    endgenerate

    always_comb begin
        irq_nxt = |(ist_nxt & ien_nxt);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OK;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OK;
            pw_r <= '{plsc_scale_e'(SCALE_RST), LIMIT_RST}; // see [R4]
            ist_r <= INT_RST;
            ien_r <= INT_RST;
            link_up_d_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (ce) begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            pw_r <= pw_nxt;
            ist_r <= ist_nxt;
            ien_r <= ien_nxt;
            link_up_d_r <= link_up_d_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////
    plsc_msg_tx u_msg (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .kick(ce && kick),
        .power(pw_nxt),
        .msg_power(msg_power),
        .msg_valid(msg_valid),
        .msg_ready(msg_ready)
    );

    ////////////////////////////////////////////////////////////////////
    a_port_number: assert property ( // see [R1]
        (ce && s_axi_arvalid && !arready_r && !rvalid_r
         && s_axi_araddr == OFF_LINK_CAP && ROOT_PORT)
        |=> s_axi_rdata[LCAP_PORT_LSB +: 8] == 8'h01)
        else $error("port number not 0x01");

    a_refclk_bit: assert property ( // see [R2]
        (ce && s_axi_arvalid && !arready_r && !rvalid_r
         && s_axi_araddr == OFF_LINK_STAT)
        |=> s_axi_rdata[12] == COMMON_REFCLK)
        else $error("slot clock bit wrong");

    a_scale_read: assert property ( // see [R3]
        (ce && s_axi_arvalid && !arready_r && !rvalid_r
         && s_axi_araddr == OFF_SLOT_CAP && SLOT_EN)
        |=> s_axi_rdata[SCAP_SCALE_LSB +: 2] == $past(pw_r.scale))
        else $error("scale readback wrong");

    a_scale_reset: assert property (@(posedge aclk) // see [R4]
        $rose(aresetn) |-> pw_r.scale == PLSC_SCALE_1X)
        else $error("scale not zero after reset");

    sequence s_scale_write;
        ce && do_wr && aw_addr_r == OFF_SLOT_CTRL && w_strb_r[1] && SLOT_EN;
    endsequence
    a_write_sends: assert property ( // see [R5]
        s_scale_write |-> ##[1:4] msg_valid)
        else $error("no power limit message after scale write");

    a_sdn_flag: assert property ( // see [R7]
        (ce && link_up_d_r && !link_up && SURPRISE_DOWN_REP && ROOT_PORT)
        |=> ist_r[INT_SDN_BIT])
        else $error("surprise down not recorded");

    a_slot_absent: assert property ( // see [R8]
        (ce && s_axi_arvalid && !arready_r && !rvalid_r
         && s_axi_araddr == OFF_SLOT_CAP && !SLOT_EN)
        |=> s_axi_rresp == RESP_ERR)
        else $error("slot capability visible without slot");

    a_caps_fixed: assert property ( // see [R9]
        (ce && s_axi_arvalid && !arready_r && !rvalid_r
         && s_axi_araddr == OFF_LINK_CAP)
        |=> s_axi_rdata[LCAP_DLLA_BIT] == (ROOT_PORT && DLL_ACTIVE_REP))
        else $error("link capability bit not the built value");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == |(ist_r & ien_r))
        else $error("interrupt output disagrees with status");

endmodule

//--- bench/plsc_link_model.sv
`timescale 1ns/1ns
module plsc_link_model
    import plsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic msg_valid,
    input wire logic [2:0] stall,
    output logic msg_ready
);
    int wait_cnt;

    // link layer takes a posted message after a variable number of cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            msg_ready <= 1'b0;
            wait_cnt <= 0;
        end else if (msg_ready) begin
            msg_ready <= 1'b0;
            wait_cnt <= 0;
        end else if (msg_valid) begin
            if (wait_cnt >= int'(stall)) begin
                msg_ready <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

//--- bench/pcie_link_slot_capability_config_tb_top.sv
`timescale 1ns/1ns
module pcie_link_slot_capability_config_tb_top
    import plsc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic link_up = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [2:0] stall = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, msg_valid, msg_ready, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    plsc_power_s msg_power, pw;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    plsc_power_s exp_m[$];
    int mismatches = 0, tests_run = 0;
    logic [7:0] lim;
    logic [1:0] sc;
    // second build: not a root port, SLOT_IMPL set, other options off
    logic [31:0] rdata_b;
    logic [1:0] rresp_b;
    logic rvalid_b;
    logic [33:0] exp_rb[$];

    plsc_top #(
        .ROOT_PORT(1'b1),
        .DLL_ACTIVE_REP(1'b1),
        .SURPRISE_DOWN_REP(1'b1),
        .COMMON_REFCLK(1'b1),
        .SLOT_IMPL(1'b1)
    ) DUT (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .link_up(link_up),
        .msg_power(msg_power), .msg_valid(msg_valid),
        .msg_ready(msg_ready), .irq(irq)
    );

    plsc_top #(
        .ROOT_PORT(1'b0),
        .DLL_ACTIVE_REP(1'b0),
        .SURPRISE_DOWN_REP(1'b0),
        .COMMON_REFCLK(1'b0),
        .SLOT_IMPL(1'b1)
    ) DUT_B (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(), .s_axi_rdata(rdata_b),
        .s_axi_rresp(rresp_b), .s_axi_rvalid(rvalid_b),
        .s_axi_rready(s_axi_rready), .link_up(link_up),
        .msg_power(), .msg_valid(), .msg_ready(1'b0), .irq()
    );

    plsc_link_model partner (
        .aclk(aclk), .aresetn(aresetn), .msg_valid(msg_valid),
        .stall(stall), .msg_ready(msg_ready)
    );

    initial begin
        forever #5 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic note(string what, logic [33:0] e, logic [33:0] s);
        tests_run++;
        if (e !== s) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic cmp_resp(logic [1:0] e);
        note("bresp", {32'h0, e}, {32'h0, s_axi_bresp});
    endtask

    task automatic cmp_read(logic [33:0] e, logic [33:0] s);
        note("rresp_rdata", e, s);
    endtask

    task automatic cmp_msg(plsc_power_s e);
        note("msg_power", {24'h0, e}, {24'h0, msg_power});
    endtask

    task automatic cmp_irq(logic e);
        note("irq", {33'h0, e}, {33'h0, irq});
    endtask

    task automatic timeout();
        mismatches++;
        $display("[ERR] wait expected handshake seen none");
        report_and_stop();
    endtask

    // results are matched to notes in the order they appear
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() > 0) cmp_resp(exp_b.pop_front());
            else note("extra bresp", 34'h0, 34'h1);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_r.size() > 0) begin
                cmp_read(exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
            end else begin
                note("extra rdata", 34'h0, 34'h1);
            end
        end
        if (rvalid_b && s_axi_rready && exp_rb.size() > 0) begin
            cmp_read(exp_rb.pop_front(), {rresp_b, rdata_b});
        end
        if (msg_valid && msg_ready) begin
            if (exp_m.size() > 0) cmp_msg(exp_m.pop_front());
            else note("extra msg", 34'h0, 34'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [3:0] st,
                          logic [1:0] er);
        int n;
        exp_b.push_back(er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) timeout();
    endtask

    task automatic axi_rd(logic [7:0] a, logic [33:0] e);
        int n;
        exp_r.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) timeout();
    endtask

    task automatic wait_irq(logic e);
        int n;
        for (n = 0; n < 20 && irq !== e; n++) @(posedge aclk);
        cmp_irq(e);
        if (irq !== e) timeout();
    endtask

    task automatic wait_msgs();
        int n;
        for (n = 0; n < 100 && exp_m.size() > 0; n++) @(posedge aclk);
        if (exp_m.size() > 0) timeout();
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h5ed1e315));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        exp_rb.push_back(34'h0);
        axi_rd(OFF_LINK_CAP, {2'h0, PORT_NUMBER, 24'h180000});
        exp_rb.push_back(34'h0);
        axi_rd(OFF_LINK_STAT, 34'h3000);
        exp_rb.push_back(34'h0);
        axi_rd(OFF_PCIE_CAP, 34'h100);
        exp_rb.push_back({2'h2, 32'h0});
        axi_rd(OFF_SLOT_CAP, 34'h0);
        axi_rd(OFF_INT_STAT, 34'h0);
        $display("test reset_values done");
        axi_wr(OFF_LINK_CAP, 32'hFFFFFFFF, 4'hF, 2'h0);
        axi_rd(OFF_LINK_CAP, {2'h0, PORT_NUMBER, 24'h180000});
        axi_wr(8'h20, 32'h1, 4'hF, 2'h2);
        axi_rd(8'h20, {2'h2, 32'h0});
        $display("test read_only done");
        for (int c = 0; c < 4; c++) begin
            sc = 2'(c);
            lim = 8'($urandom);
            stall <= 3'($urandom_range(5));
            pw.scale = plsc_scale_e'(sc);
            pw.limit = lim;
            exp_m.push_back(pw);
            axi_wr(OFF_SLOT_CTRL, {22'h0, sc, lim}, 4'h3, 2'h0);
            wait_msgs();
            axi_rd(OFF_SLOT_CAP, {17'h0, sc, lim, 7'h0});
        end
        $display("test power_scale done");
        wait_irq(1'b0);
        axi_rd(OFF_INT_STAT, 34'h2);
        axi_wr(OFF_INT_EN, 32'h3, 4'h1, 2'h0);
        wait_irq(1'b1);
        axi_wr(OFF_INT_CLR, 32'h2, 4'h1, 2'h0);
        wait_irq(1'b0);
        axi_rd(OFF_INT_STAT, 34'h0);
        link_up <= 1'b0;
        wait_irq(1'b1);
        axi_rd(OFF_INT_STAT, 34'h1);
        axi_rd(OFF_LINK_STAT, 34'h1000);
        axi_wr(OFF_INT_EN, 32'h2, 4'h1, 2'h0);
        axi_wr(OFF_INT_CLR, 32'h1, 4'h1, 2'h0);
        wait_irq(1'b0);
        link_up <= 1'b1;
        axi_rd(OFF_LINK_STAT, 34'h3000);
        link_up <= 1'b0;
        repeat (4) @(posedge aclk);
        axi_rd(OFF_INT_STAT, 34'h1);
        wait_irq(1'b0);
        $display("test interrupts done");
        // a link drop while the enable is low must leave no trace
        axi_wr(OFF_INT_CLR, 32'h1, 4'h1, 2'h0);
        ce <= 1'b0;
        link_up <= 1'b1;
        repeat (2) @(posedge aclk);
        link_up <= 1'b0;
        repeat (2) @(posedge aclk);
        ce <= 1'b1;
        axi_rd(OFF_INT_STAT, 34'h0);
        $display("test clock_enable done");
        report_and_stop();
    end
endmodule
